// *** pkg/rfm_map.vh ***
// register offsets, field positions and reset values of the rail fault mask and output-1 good tree block
// assumes an 8-bit register port with 8-bit offsets, driven from the device's serial interface logic
`ifndef RFM_MAP_VH
`define RFM_MAP_VH

`define RFM_OFS_FAULT_MASK_A       8'ha2
`define RFM_OFS_FAULT_MASK_B       8'ha3
`define RFM_OFS_GOOD_TREE_MASK_A   8'ha4
`define RFM_OFS_GOOD_TREE_MASK_B   8'ha5

`define RFM_RST_FAULT_MASK_A       8'h00
`define RFM_RST_FAULT_MASK_B       8'h20
`define RFM_RST_GOOD_TREE_MASK_A   8'h00
`define RFM_RST_GOOD_TREE_MASK_B   8'h00
`define RFM_READ_UNMAPPED          8'h00

// fault mask A and good-tree mask A share this layout
`define RFM_BIT_A_LINEAR_REG_2     7
`define RFM_BIT_A_LOAD_SWITCH_A1   6
`define RFM_BIT_A_STEP_DOWN_6      5
`define RFM_BIT_A_STEP_DOWN_1      0

// fault mask B
`define RFM_BIT_B_RSVD_RO          7
`define RFM_BIT_B_RSVD_ZERO        6
`define RFM_BIT_B_RSVD_ONE         5
`define RFM_BIT_B_LINEAR_REG_1     4
`define RFM_BIT_B_TERMINATION_REG  3
`define RFM_BIT_B_LOAD_SWITCH_B2   2
`define RFM_BIT_B_LOAD_SWITCH_B1   1
`define RFM_BIT_B_LINEAR_REG_3     0
`define RFM_FAULT_B_RAILS          5

// good-tree mask B
`define RFM_BIT_T_CONTROL_5        7
`define RFM_BIT_T_CONTROL_4        6
`define RFM_BIT_T_CONTROL_2        5
`define RFM_BIT_T_CONTROL_1        4
`define RFM_BIT_T_TERMINATION_REG  3
`define RFM_BIT_T_SWITCH_B2_LIN_1  2
`define RFM_BIT_T_LOAD_SWITCH_B1   1
`define RFM_BIT_T_LINEAR_REG_3     0

`endif

// *** src/rfm_sync.v ***
// two-flop synchroniser for a group of asynchronous level inputs
// assumes inputs are slow levels; bits are not guaranteed coherent with each other
`timescale 1ns/1ps
module rfm_sync #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             clk,
    input  wire             reset,
    // levels
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge clk) begin
        if (reset) begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // rfm_sync

// *** src/rfm_top.v ***
// rail fault-shutdown masking and output-1 power-good tree
// assumes rail fault, power-good and control pins are asynchronous levels, active high,
// and the register port is driven by same-clock serial interface logic
`timescale 1ns/1ps
`include "rfm_map.vh"
module rfm_top (
    // clock and reset
    input  wire       clk,
    input  wire       reset,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // rail power faults
    input  wire       fault_step_down_rail_1,
    input  wire       fault_step_down_rail_2,
    input  wire       fault_step_down_rail_3,
    input  wire       fault_step_down_rail_4,
    input  wire       fault_step_down_rail_5,
    input  wire       fault_step_down_rail_6,
    input  wire       fault_load_switch_a1,
    input  wire       fault_linear_reg_2,
    input  wire       fault_linear_reg_3,
    input  wire       fault_load_switch_b1,
    input  wire       fault_load_switch_b2,
    input  wire       fault_termination_reg,
    input  wire       fault_linear_reg_1,
    // rail power good
    input  wire       power_good_step_down_rail_1,
    input  wire       power_good_step_down_rail_2,
    input  wire       power_good_step_down_rail_3,
    input  wire       power_good_step_down_rail_4,
    input  wire       power_good_step_down_rail_5,
    input  wire       power_good_step_down_rail_6,
    input  wire       power_good_load_switch_a1,
    input  wire       power_good_linear_reg_2,
    input  wire       power_good_linear_reg_3,
    input  wire       power_good_load_switch_b1,
    input  wire       power_good_switch_b2_or_linear_reg_1,
    input  wire       power_good_termination_reg,
    // control input pins
    input  wire       control_input_1,
    input  wire       control_input_2,
    input  wire       control_input_4,
    input  wire       control_input_5,
    // results
    output reg        shutdown_request,
    output reg        general_output_1
);

    // mask registers
    reg  [7:0] rail_fault_mask_a;
    reg  [6:0] rail_fault_mask_b;
    reg  [7:0] output1_good_tree_mask_a;
    reg  [7:0] output1_good_tree_mask_b;

    // reset values kept byte wide; mask B stores only bits 6..0
    localparam [7:0] RST_FAULT_A = `RFM_RST_FAULT_MASK_A;
    localparam [7:0] RST_FAULT_B = `RFM_RST_FAULT_MASK_B;
    localparam [7:0] RST_TREE_A  = `RFM_RST_GOOD_TREE_MASK_A;
    localparam [7:0] RST_TREE_B  = `RFM_RST_GOOD_TREE_MASK_B;

    // raw pin groups, in mask bit order
    wire [7:0] fault_a_pins;
    wire [4:0] fault_b_pins;
    wire [7:0] good_a_pins;
    wire [7:0] good_b_pins;

    // synchronised pin groups
    wire [7:0] fault_a_sync;
    wire [4:0] fault_b_sync;
    wire [7:0] good_a_sync;
    wire [7:0] good_b_sync;

    // pin groups after masking
    wire [7:0] fault_a_live;
    wire [4:0] fault_b_live;
    wire [7:0] good_a_seen;
    wire [7:0] good_b_seen;

    // combinational results
    reg  [7:0] next_rdata;
    wire [7:0] fault_mask_b_view;
    wire       fault_hit;
    wire       tree_good;

    // each group in the bit order of the mask that gates it
    assign fault_a_pins = {fault_linear_reg_2,
                           fault_load_switch_a1,
                           fault_step_down_rail_6,
                           fault_step_down_rail_5,
                           fault_step_down_rail_4,
                           fault_step_down_rail_3,
                           fault_step_down_rail_2,
                           fault_step_down_rail_1};
    assign fault_b_pins = {fault_linear_reg_1,
                           fault_termination_reg,
                           fault_load_switch_b2,
                           fault_load_switch_b1,
                           fault_linear_reg_3};
    assign good_a_pins  = {power_good_linear_reg_2,
                           power_good_load_switch_a1,
                           power_good_step_down_rail_6,
                           power_good_step_down_rail_5,
                           power_good_step_down_rail_4,
                           power_good_step_down_rail_3,
                           power_good_step_down_rail_2,
                           power_good_step_down_rail_1};
    // control pins share good-tree mask B with the remaining rails
    assign good_b_pins  = {control_input_5,
                           control_input_4,
                           control_input_2,
                           control_input_1,
                           power_good_termination_reg,
                           power_good_switch_b2_or_linear_reg_1,
                           power_good_load_switch_b1,
                           power_good_linear_reg_3};

    rfm_sync #(
        .WIDTH (8)
    ) u_sync_fault_a (
        .clk      (clk),
        .reset    (reset),
        .async_in (fault_a_pins),
        .sync_out (fault_a_sync)
    );

    rfm_sync #(
        .WIDTH (5)
    ) u_sync_fault_b (
        .clk      (clk),
        .reset    (reset),
        .async_in (fault_b_pins),
        .sync_out (fault_b_sync)
    );

    rfm_sync #(
        .WIDTH (8)
    ) u_sync_good_a (
        .clk      (clk),
        .reset    (reset),
        .async_in (good_a_pins),
        .sync_out (good_a_sync)
    );

    // pin levels and remaining rails, in good-tree mask B bit order
    rfm_sync #(
        .WIDTH (8)
    ) u_sync_good_b (
        .clk      (clk),
        .reset    (reset),
        .async_in (good_b_pins),
        .sync_out (good_b_sync)
    );

    // register writes; reserved bits 6 and 5 of mask B are stored as written
    always @(posedge clk) begin
        if (reset) begin
            rail_fault_mask_a        <= RST_FAULT_A;
            rail_fault_mask_b        <= RST_FAULT_B[`RFM_BIT_B_RSVD_ZERO:0];
            output1_good_tree_mask_a <= RST_TREE_A;
            output1_good_tree_mask_b <= RST_TREE_B;
        end else if (reg_wr) begin
            if (reg_addr == `RFM_OFS_FAULT_MASK_A) begin
                rail_fault_mask_a <= reg_wdata;
            end else if (reg_addr == `RFM_OFS_FAULT_MASK_B) begin
                rail_fault_mask_b <= reg_wdata[`RFM_BIT_B_RSVD_ZERO:0];
            end else if (reg_addr == `RFM_OFS_GOOD_TREE_MASK_A) begin
                output1_good_tree_mask_a <= reg_wdata;
            end else if (reg_addr == `RFM_OFS_GOOD_TREE_MASK_B) begin
                output1_good_tree_mask_b <= reg_wdata;
            end
        end
    end

    // top bit of mask B is read-only zero
    assign fault_mask_b_view = {1'b0, rail_fault_mask_b};

    // read decode; unmapped offsets read as zero
    always @* begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            if (reg_addr == `RFM_OFS_FAULT_MASK_A) begin
                next_rdata = rail_fault_mask_a;
            end else if (reg_addr == `RFM_OFS_FAULT_MASK_B) begin
                next_rdata = fault_mask_b_view;
            end else if (reg_addr == `RFM_OFS_GOOD_TREE_MASK_A) begin
                next_rdata = output1_good_tree_mask_a;
            end else if (reg_addr == `RFM_OFS_GOOD_TREE_MASK_B) begin
                next_rdata = output1_good_tree_mask_b;
            end else begin
                next_rdata = `RFM_READ_UNMAPPED;
            end
        end
    end

    // a set mask bit blocks that rail's fault
    assign fault_a_live = fault_a_sync & ~rail_fault_mask_a;
    assign fault_b_live = fault_b_sync & ~rail_fault_mask_b[`RFM_FAULT_B_RAILS-1:0];
    assign fault_hit    = (|fault_a_live) | (|fault_b_live);

    // masked inputs are forced good, so an all-masked tree reads good
    assign good_a_seen  = good_a_sync | output1_good_tree_mask_a;
    assign good_b_seen  = good_b_sync | output1_good_tree_mask_b;
    assign tree_good    = (&good_a_seen) & (&good_b_seen);

    // shutdown request latches until reset: the rails are going down anyway,
    // and a fault that clears itself must not bring them back
    always @(posedge clk) begin
        if (reset) begin
            shutdown_request <= 1'b0;
            general_output_1 <= 1'b0;
            reg_rdata        <= 8'h00;
        end else begin
            shutdown_request <= shutdown_request | fault_hit;
            general_output_1 <= tree_good;
            reg_rdata        <= next_rdata;
        end
    end

endmodule // rfm_top

// *** testbench/rfm_monitor.sv ***
// checker for the fault mask and output-1 good tree block, bound to rfm_top
// assumes one clock, synchronous active-high reset, 3-edge pin latency
`timescale 1ns/1ps
module rfm_monitor (
    // clock and reset
    input logic       clk,
    input logic       reset,
    // register port
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    // one watched rail and the results
    input logic       fault_step_down_rail_3,
    input logic       power_good_step_down_rail_3,
    input logic       shutdown_request,
    input logic       general_output_1
);
    logic fm;
    logic gm;
    // only bit 2 is shadowed; the other rails are judged by the bench
    always @(posedge clk) begin
        if (reset) begin
            fm <= 1'b0;
            gm <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == 8'ha2)
                fm <= reg_wdata[2];
            if (reg_addr == 8'ha4)
                gm <= reg_wdata[2];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_clears: assert property (disable iff (1'b0) reset |=>
        !shutdown_request && !general_output_1 && reg_rdata == 8'h00) else $error("reset did not clear");
    a_shutdown_sticky: assert property (shutdown_request |=> shutdown_request)
        else $error("shutdown dropped");
    a_fault_unmasked: assert property ((fault_step_down_rail_3 && !fm)[*3] |=> shutdown_request)
        else $error("unmasked fault ignored");
    a_good_missing: assert property ((!power_good_step_down_rail_3 && !gm)[*3] |=> !general_output_1)
        else $error("tree good with rail low");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'ha2 || reg_addr > 8'ha5) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mask_b_top: assert property (reg_rd && reg_addr == 8'ha3 |=> !reg_rdata[7])
        else $error("read-only bit set");
    a_fault_readback: assert property (reg_rd && reg_addr == 8'ha2 |=> reg_rdata[2] == $past(fm))
        else $error("fault mask readback");
    a_tree_readback: assert property (reg_rd && reg_addr == 8'ha4 |=> reg_rdata[2] == $past(gm))
        else $error("tree mask readback");
    c_shutdown: cover property ($rose(shutdown_request));
    c_good: cover property ($rose(general_output_1));
    c_unmapped: cover property (reg_rd && reg_addr == 8'ha6);
endmodule // rfm_monitor

// *** testbench/rfm_host.sv ***
// host model: register writes and reads, one transfer at a time
// assumes calls from the bench; released lines show the inverse of the last value
`timescale 1ns/1ps
module rfm_host (
    // clock and read data
    input  wire       clk,
    input  wire [7:0] reg_rdata,
    // request
    output reg  [7:0] reg_addr = 8'h00,
    output reg  [7:0] reg_wdata = 8'h00,
    output reg        reg_wr = 1'b0,
    output reg        reg_rd = 1'b0
);
    task wr(input [7:0] a, input [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = (a == 8'ha3) ? {d[7], 2'b01, d[4:0]} : d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // rfm_host

// *** testbench/tb.sv ***
// bench: register map, fault masking per rail, output-1 good tree per input
// assumes rfm_top with 3-edge pin latency and rfm_host for register traffic
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [12:0] flt = 13'h0;
    logic [15:0] g = 16'h0;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, shutdown_request, general_output_1;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [7:0]  d;
    rfm_host i_rfm_host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    rfm_top i_rfm_top (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .shutdown_request,
        .general_output_1, .fault_step_down_rail_1(flt[0]), .fault_step_down_rail_2(flt[1]),
        .fault_step_down_rail_3(flt[2]), .fault_step_down_rail_4(flt[3]), .fault_step_down_rail_5(flt[4]),
        .fault_step_down_rail_6(flt[5]), .fault_load_switch_a1(flt[6]), .fault_linear_reg_2(flt[7]),
        .fault_linear_reg_3(flt[8]), .fault_load_switch_b1(flt[9]), .fault_load_switch_b2(flt[10]),
        .fault_termination_reg(flt[11]), .fault_linear_reg_1(flt[12]), .power_good_step_down_rail_1(g[0]),
        .power_good_step_down_rail_2(g[1]), .power_good_step_down_rail_3(g[2]), .power_good_step_down_rail_4(g[3]),
        .power_good_step_down_rail_5(g[4]), .power_good_step_down_rail_6(g[5]), .power_good_load_switch_a1(g[6]),
        .power_good_linear_reg_2(g[7]), .power_good_linear_reg_3(g[8]), .power_good_load_switch_b1(g[9]),
        .power_good_switch_b2_or_linear_reg_1(g[10]), .power_good_termination_reg(g[11]),
        .control_input_1(g[12]), .control_input_2(g[13]), .control_input_4(g[14]), .control_input_5(g[15]));
    initial forever #12.5 clk = ~clk;
    // ceiling well above the roughly 510 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end
    task chk(input logic [7:0] act, input logic [7:0] exp);
        checked++;
        if (act !== exp) begin
            mismatches++;
            $display("FAIL %0t read %h expected %h", $time, act, exp);
        end
    endtask
    task chk_bit(input logic act, input logic exp);
        checked++;
        if (act !== exp) begin
            mismatches++;
            $display("FAIL %0t output %b expected %b", $time, act, exp);
        end
    endtask
    // callers sit at time zero or on a falling edge, so reset spans two rising edges
    task rst;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
    endtask
    task settle;
        repeat (3) @(negedge clk);
    endtask
    task t_regs;
        logic [7:0] wd [5];
        logic [7:0] we [5];
        wd = '{8'ha5, 8'hff, 8'h5a, 8'hc3, 8'h77};
        we = '{8'ha5, 8'h3f, 8'h5a, 8'hc3, 8'h00};
        rst();
        for (int k = 0; k < 4; k++) begin
            i_rfm_host.rd(8'ha2 + k[7:0], d);
            chk(d, (k == 1) ? 8'h20 : 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            i_rfm_host.wr(8'ha2 + k[7:0], wd[k]);
            i_rfm_host.rd(8'ha2 + k[7:0], d);
            chk(d, we[k]);
        end
    endtask
    task t_fault;
        logic [12:0] m;
        for (int i = 0; i < 13; i++) begin
            m = 13'h1 << i;
            rst();
            i_rfm_host.wr(8'ha2, m[7:0]);
            i_rfm_host.wr(8'ha3, {3'b001, m[12:8]});
            flt[i] = 1'b1;
            settle();
            chk_bit(shutdown_request, 1'b0);
            i_rfm_host.wr(8'ha2, 8'h00);
            i_rfm_host.wr(8'ha3, 8'h20);
            settle();
            chk_bit(shutdown_request, 1'b1);
            // the request must outlive the fault that raised it
            flt[i] = 1'b0;
            settle();
            chk_bit(shutdown_request, 1'b1);
        end
    endtask
    task t_tree;
        logic [15:0] m;
        rst();
        g = 16'hffff;
        settle();
        chk_bit(general_output_1, 1'b1);
        for (int i = 0; i < 16; i++) begin
            m = 16'h1 << i;
            g = ~m;
            settle();
            chk_bit(general_output_1, 1'b0);
            i_rfm_host.wr(8'ha4, m[7:0]);
            i_rfm_host.wr(8'ha5, m[15:8]);
            settle();
            chk_bit(general_output_1, 1'b1);
            i_rfm_host.wr(8'ha4, 8'h00);
            i_rfm_host.wr(8'ha5, 8'h00);
        end
        g = 16'h0;
        i_rfm_host.wr(8'ha4, 8'hff);
        i_rfm_host.wr(8'ha5, 8'hff);
        settle();
        chk_bit(general_output_1, 1'b1);
    endtask
    task test_done;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        t_regs();
        t_fault();
        t_tree();
        test_done();
    end
endmodule // tb
bind rfm_top rfm_monitor i_rfm_monitor (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fault_step_down_rail_3, .power_good_step_down_rail_3, .shutdown_request, .general_output_1);
